/* include/rcs_pkg.sv */
`default_nettype none
package rcs_pkg;
    // configuration word placement and field positions
    localparam logic [15:0] CFG_WORD_ADDR = 16'h2007;
    localparam logic [15:0] CAL_OSC_ADDR = 16'h2009;
    localparam logic [15:0] CAL_BOR_ADDR = 16'h2008;
    localparam int CFG_BOR_HI = 9;
    localparam int CFG_BOR_LO = 8;
    localparam int CFG_FREQ = 7;
    localparam int CFG_LOCK = 6;
    localparam int CFG_PIN = 5;
    localparam int CFG_POWERUP_DELAY_TIMER = 4;
    localparam int CFG_WDT = 3;
    localparam int CFG_OSC_HI = 2;
    localparam int CFG_OSC_LO = 0;
    localparam logic [15:0] CFG_ERASED = 16'hffff;
    localparam logic [15:0] CFG_UNIMPL_MASK = 16'hfc00;

    // register port map
    localparam logic [15:0] POWER_CONTROL_REG_ADDR = 16'h008e;
    localparam logic [15:0] STAT_ADDR = 16'h0090;
    localparam int POWER_CONTROL_REG_BOR_BIT = 0;
    localparam int POWER_CONTROL_REG_POR_BIT = 1;
    localparam int POWER_CONTROL_REG_SBOR_BIT = 4;

    // brown-out modes
    localparam logic [1:0] BOR_ALWAYS = 2'b11;
    localparam logic [1:0] BOR_RUN_ONLY = 2'b10;
    localparam logic [1:0] BOR_SOFT = 2'b01;

    // timing at 40 MHz
    localparam int CLK_HZ = 40_000_000;
    localparam int POWERUP_DELAY_TIMER_MS = 64;
    localparam int POWERUP_DELAY_TIMER_CYCLES = CLK_HZ / 1000 * POWERUP_DELAY_TIMER_MS;
    localparam int GLITCH_NS = 200;
    localparam int GLITCH_CYCLES = (GLITCH_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int BOR_QUAL_NS = 100;
    localparam int BOR_QUAL_CYCLES = (BOR_QUAL_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

    typedef enum logic [2:0] {
        RCS_LOW_POWER_CRYSTAL, RCS_CRYSTAL_MEDIUM, RCS_HIGH_SPEED_CRYSTAL,
        RCS_EXTERNAL_CLOCK_INPUT, RCS_INTERNAL_CLOCK_WITH_IO,
        RCS_INTERNAL_CLOCK_WITH_OUTPUT, RCS_RESISTOR_CAPACITOR_IO,
        RCS_RESISTOR_CAPACITOR_OUT
    } rcs_osc_e;
endpackage : rcs_pkg
`default_nettype wire

/* hdl/rcs_sequencer.sv */
// Behaviour
// R1 - config bit zero means programmed
// R2 - decode brown-out mode field 11/10/01/00
// R3 - mode 01 software enable controls brown-out
// R4 - mode 10 off in sleep, soft bit ignored
// R5 - frequency bit selects 8 or 4 MHz
// R6 - lock bit zero protects; unlock erases all
// R7 - pin select: external reset or input
// R8 - weak pull-up while pin is reset
// R9 - delay enable bit zero enables timer
// R10 - watchdog enable bit one enables
// R11 - three-bit oscillator select, eight modes
// R12 - brown-out enable never enables power-up timer
// R13 - reset stops internal/rc oscillator; code stops it only on pin reset, not on por, brown-out or watchdog reset
// R14 - power-up timer only after por/bor
// R15 - timer clocked by dedicated rc tick
// R16 - watchdog reset never drives pin low
// R17 - glitch filter on external reset
// R18 - brown-out qualified by time then reset
// R19 - hold until supply ok, then delay
// R20 - brown-out during delay restarts it
// R21 - watchdog wake is not a reset
// R22 - calibration words survive bulk erase
// R23 - delay after por; settle timer after delay
// R24 - por flag cleared on por, software sets
// R25 - chip reset is or of sources
`timescale 1ns/1ps
`default_nettype none
module rcs_sequencer
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // configuration and analog detectors
    input wire logic [15:0] cfg_word,
    input wire logic por_active,
    input wire logic supply_below_threshold,
    input wire logic rc_tick,
    input wire logic sleep_active,
    input wire logic crystal_settled,
    input wire logic watchdog_timeout,
    input wire logic watchdog_wake,
    input wire logic bulk_erase_req,
    // shared reset pin
    input wire logic external_reset_n,
    output logic pin_pullup_en,
    output logic pin_drive_low,
    output logic pin_drive_oe,
    output logic pin_digital_in,
    // register port
    input wire logic [15:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // decoded outputs
    output logic chip_reset,
    output logic settle_timer_run,
    output logic osc_stop,
    output logic freq_8mhz,
    output logic code_lock,
    output logic watchdog_enable,
    output logic brownout_active,
    output logic [2:0] osc_mode,
    output logic erase_program,
    output logic erase_cal
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef enum logic [1:0] {RCS_POR, RCS_HOLD, RCS_DELAY, RCS_RUN} rcs_st_e;
    typedef struct packed {
        rcs_st_e st;
        logic [31:0] dly_cnt;
        logic [7:0] flt_cnt;
        logic pin_q;
        logic [7:0] bor_cnt;
        logic por_flag;
        logic bor_flag;
        logic sbor;
        logic lock_q;
        logic powerup_delay_timer_pending;
        logic [15:0] rdata;
        logic rst;
        logic settle;
        logic ostop;
        logic erase;
        logic pull;
        logic bact;
        logic [2:0] osc;
        logic f8;
        logic lock;
        logic wdt;
        logic pdin;
    } rcs_s;
    rcs_s cur_reg;
    rcs_s cur_next;

    // ------------------------------------------------------------
    // configuration decode
    // ------------------------------------------------------------
    logic [1:0] bor_mode;
    logic bor_en;
    logic powerup_delay_timer_en;
    logic pin_is_reset;
    logic osc_int_rc;
    logic pin_rst;
    logic bor_qual;
    always_comb
    begin
        bor_mode = cfg_word[rcs_pkg::CFG_BOR_HI:rcs_pkg::CFG_BOR_LO]; // R1
        bor_en = 1'b0;
        if (bor_mode == rcs_pkg::BOR_ALWAYS) // R2
        begin
            bor_en = 1'b1;
        end
        else if (bor_mode == rcs_pkg::BOR_RUN_ONLY) // R4
        begin
            bor_en = !sleep_active;
        end
        else if (bor_mode == rcs_pkg::BOR_SOFT) // R3
        begin
            bor_en = cur_reg.sbor;
        end
        powerup_delay_timer_en = !cfg_word[rcs_pkg::CFG_POWERUP_DELAY_TIMER]; // R9 R12
        pin_is_reset = cfg_word[rcs_pkg::CFG_PIN]; // R7
        osc_int_rc = cfg_word[rcs_pkg::CFG_OSC_HI]; // R11 R13
        pin_rst = pin_is_reset && !cur_reg.pin_q; // R7 R17
        bor_qual = bor_en && (cur_reg.bor_cnt >= 8'(rcs_pkg::BOR_QUAL_CYCLES)); // R18
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        cur_next = cur_reg;
        // filter: pin level taken only after it holds steady
        if (external_reset_n == cur_reg.pin_q)
        begin
            cur_next.flt_cnt = 8'h00;
        end
        else if (cur_reg.flt_cnt >= 8'(rcs_pkg::GLITCH_CYCLES - 1)) // R17
        begin
            cur_next.pin_q = external_reset_n;
            cur_next.flt_cnt = 8'h00;
        end
        else
        begin
            cur_next.flt_cnt = cur_reg.flt_cnt + 8'h01;
        end
        if (supply_below_threshold && bor_en) // R18
        begin
            if (!bor_qual)
            begin
                cur_next.bor_cnt = cur_reg.bor_cnt + 8'h01;
            end
        end
        else
        begin
            cur_next.bor_cnt = 8'h00;
        end
        // sequencer
        case (cur_reg.st)
            RCS_POR:
            begin
                cur_next.por_flag = 1'b0; // R24
                cur_next.powerup_delay_timer_pending = 1'b1; // R14
                if (!por_active)
                begin
                    cur_next.st = RCS_HOLD; // R23
                end
            end
            RCS_HOLD:
            begin
                cur_next.dly_cnt = 32'h0000_0000;
                if (!supply_below_threshold && !pin_rst && !watchdog_timeout) // R19
                begin
                    cur_next.st = (powerup_delay_timer_en && cur_reg.powerup_delay_timer_pending) ? RCS_DELAY : RCS_RUN;
                    cur_next.powerup_delay_timer_pending = 1'b0;
                end
            end
            RCS_DELAY:
            begin
                if (bor_qual) // R20
                begin
                    cur_next.st = RCS_HOLD;
                    cur_next.powerup_delay_timer_pending = 1'b1;
                    // a brown-out mid-delay is a brown-out reset of its own
                    cur_next.bor_flag = 1'b0; // R18
                end
                else if (rc_tick) // R15
                begin
                    if (cur_reg.dly_cnt >= 32'(rcs_pkg::POWERUP_DELAY_TIMER_CYCLES - 1))
                    begin
                        cur_next.st = RCS_RUN;
                    end
                    cur_next.dly_cnt = cur_reg.dly_cnt + 32'h0000_0001;
                end
            end
            default:
            begin
                if (bor_qual) // R25
                begin
                    cur_next.st = RCS_HOLD;
                    cur_next.powerup_delay_timer_pending = 1'b1; // R14
                    cur_next.bor_flag = 1'b0;
                end
                else if (pin_rst || (watchdog_timeout && !watchdog_wake)) // R21
                begin
                    cur_next.st = RCS_HOLD;
                end
            end
        endcase
        if (por_active)
        begin
            cur_next.st = RCS_POR;
        end
        // register writes; hardware clears win over software sets
        if (reg_wr && reg_addr == rcs_pkg::POWER_CONTROL_REG_ADDR)
        begin
            if (cur_reg.st != RCS_POR) // R24
            begin
                cur_next.por_flag = reg_wdata[rcs_pkg::POWER_CONTROL_REG_POR_BIT];
            end
            if (!((cur_reg.st == RCS_RUN || cur_reg.st == RCS_DELAY) && bor_qual))
            begin
                cur_next.bor_flag = reg_wdata[rcs_pkg::POWER_CONTROL_REG_BOR_BIT];
            end
            cur_next.sbor = reg_wdata[rcs_pkg::POWER_CONTROL_REG_SBOR_BIT]; // R3
        end
        cur_next.rdata = 16'h0000;
        if (reg_rd && reg_addr == rcs_pkg::POWER_CONTROL_REG_ADDR)
        begin
            cur_next.rdata[rcs_pkg::POWER_CONTROL_REG_POR_BIT] = cur_reg.por_flag;
            cur_next.rdata[rcs_pkg::POWER_CONTROL_REG_BOR_BIT] = cur_reg.bor_flag;
            cur_next.rdata[rcs_pkg::POWER_CONTROL_REG_SBOR_BIT] = cur_reg.sbor;
        end
        else if (reg_rd && reg_addr == rcs_pkg::CFG_WORD_ADDR)
        begin
            cur_next.rdata = cfg_word | rcs_pkg::CFG_UNIMPL_MASK;
        end
        else if (reg_rd && reg_addr == rcs_pkg::STAT_ADDR)
        begin
            cur_next.rdata = {13'h0000, cur_reg.rst, bor_en, powerup_delay_timer_en};
        end
        // lock release triggers full erase
        cur_next.lock_q = cfg_word[rcs_pkg::CFG_LOCK];
        cur_next.erase = bulk_erase_req ||
            (cfg_word[rcs_pkg::CFG_LOCK] && !cur_reg.lock_q); // R6
        // registered outputs
        cur_next.rst = (cur_next.st != RCS_RUN); // R25
        cur_next.settle = (cur_reg.st == RCS_RUN) && !cfg_word[rcs_pkg::CFG_OSC_HI]
            && (cfg_word[rcs_pkg::CFG_OSC_HI:rcs_pkg::CFG_OSC_LO]
            != rcs_pkg::RCS_EXTERNAL_CLOCK_INPUT)
            && !crystal_settled; // R23
        cur_next.ostop = osc_int_rc && pin_rst; // R13
        cur_next.pull = pin_is_reset; // R8
        cur_next.pdin = !pin_is_reset && external_reset_n; // R7
        cur_next.bact = bor_en;
        cur_next.osc = cfg_word[rcs_pkg::CFG_OSC_HI:rcs_pkg::CFG_OSC_LO]; // R11
        cur_next.f8 = cfg_word[rcs_pkg::CFG_FREQ]; // R5
        cur_next.lock = !cfg_word[rcs_pkg::CFG_LOCK]; // R6
        cur_next.wdt = cfg_word[rcs_pkg::CFG_WDT]; // R10
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            cur_reg <= '0;
            cur_reg.st <= RCS_POR;
            cur_reg.pin_q <= 1'b1;
            cur_reg.rst <= 1'b1;
            cur_reg.lock_q <= 1'b1;
            cur_reg.powerup_delay_timer_pending <= 1'b1;
        end
        else
        begin
            cur_reg <= cur_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign chip_reset = cur_reg.rst;
    assign settle_timer_run = cur_reg.settle;
    assign osc_stop = cur_reg.ostop;
    assign pin_pullup_en = cur_reg.pull;
    assign pin_drive_low = 1'b0; // R16
    assign pin_drive_oe = 1'b0; // R16
    assign pin_digital_in = cur_reg.pdin;
    assign reg_rdata = cur_reg.rdata;
    assign brownout_active = cur_reg.bact;
    assign osc_mode = cur_reg.osc;
    assign freq_8mhz = cur_reg.f8;
    assign code_lock = cur_reg.lock;
    assign watchdog_enable = cur_reg.wdt;
    assign erase_program = cur_reg.erase;
    assign erase_cal = 1'b0; // R22

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    AST_POR_FLAG: assert property (cur_reg.st == RCS_POR |=> !cur_reg.por_flag) // R24
        else $error("por flag not cleared");
    AST_DELAY_HOLDS: assert property (cur_reg.st == RCS_DELAY |-> chip_reset) // R14
        else $error("reset released during delay");
    AST_BOR_RESTART: assert property (cur_reg.st == RCS_DELAY && bor_qual && !por_active // R20
        |=> cur_reg.st == RCS_HOLD)
        else $error("brownout did not restart delay");
    AST_NO_PIN_DRIVE: assert property (watchdog_timeout |-> !pin_drive_oe) // R16
        else $error("pin driven on watchdog");
    AST_PULLUP: assert property (rstn && cfg_word[rcs_pkg::CFG_PIN] |=> pin_pullup_en) // R8
        else $error("pullup missing");
    AST_OSC_STOP: assert property (osc_int_rc && pin_rst |=> osc_stop) // R13
        else $error("oscillator not stopped");
    AST_WAKE: assert property (cur_reg.st == RCS_RUN && watchdog_wake && !pin_rst // R21
        && !bor_qual && !por_active |=> cur_reg.st == RCS_RUN)
        else $error("wake caused reset");
    AST_LOCK: assert property (##1 code_lock == !$past(cfg_word[rcs_pkg::CFG_LOCK])) // R6
        else $error("lock decode wrong");
    AST_CAL_KEPT: assert property (!erase_cal) // R22
        else $error("calibration erased");
    AST_RUN_NODELAY: assert property (cur_reg.st == RCS_HOLD && !powerup_delay_timer_en |=> cur_reg.st != RCS_DELAY) // R9
        else $error("delay with timer off");
    AST_POR_RESET: assert property (por_active |=> chip_reset) // R25
        else $error("power-on did not hold reset");
    AST_PIN_RESET: assert property (cur_reg.st == RCS_RUN && pin_rst |=> chip_reset) // R7
        else $error("pin did not reset");
    AST_WDT_RESET: assert property (cur_reg.st == RCS_RUN && watchdog_timeout // R25
        && !watchdog_wake |=> chip_reset)
        else $error("watchdog did not reset");
    AST_BOR_RESET: assert property (cur_reg.st == RCS_RUN && bor_qual |=> chip_reset) // R18
        else $error("brownout did not reset");
    AST_BOR_FLAG: assert property (cur_reg.st inside {RCS_RUN, RCS_DELAY} && bor_qual // R18
        |=> !cur_reg.bor_flag)
        else $error("brownout flag not cleared");
    AST_SUPPLY_HOLD: assert property (cur_reg.st == RCS_HOLD && supply_below_threshold // R19
        |=> chip_reset)
        else $error("reset released below threshold");
    AST_POWERUP_DELAY_TIMER_SOURCE: assert property (cur_reg.st == RCS_HOLD && !cur_reg.powerup_delay_timer_pending // R14
        |=> cur_reg.st != RCS_DELAY)
        else $error("delay without power-on or brownout");
    AST_DELAY_TICK: assert property (cur_reg.st == RCS_DELAY && !rc_tick && !bor_qual // R15
        && !por_active |=> cur_reg.st == RCS_DELAY)
        else $error("delay ended without rc tick");
    AST_RUN_ONLY_MODE: assert property (rstn && bor_mode == rcs_pkg::BOR_RUN_ONLY // R4
        |=> brownout_active == !$past(sleep_active))
        else $error("run-only brownout mode wrong");
    AST_SOFT_MODE: assert property (rstn && bor_mode == rcs_pkg::BOR_SOFT // R3
        |=> brownout_active == $past(cur_reg.sbor))
        else $error("software brownout enable ignored");
    AST_SETTLE_AFTER: assert property (cur_reg.st != RCS_RUN |=> !settle_timer_run) // R23
        else $error("settle timer ran in reset");
    AST_PIN_INPUT: assert property (!cfg_word[rcs_pkg::CFG_PIN] |-> !pin_rst) // R7
        else $error("input pin caused reset");
    AST_UNLOCK_ERASE: assert property (cfg_word[rcs_pkg::CFG_LOCK] && !cur_reg.lock_q // R6
        |=> erase_program)
        else $error("unlock did not erase");
    AST_FREQ: assert property (rstn |=> freq_8mhz == $past(cfg_word[rcs_pkg::CFG_FREQ])) // R5
        else $error("frequency select wrong");
    AST_WDT_EN: assert property (rstn // R10
        |=> watchdog_enable == $past(cfg_word[rcs_pkg::CFG_WDT]))
        else $error("watchdog enable wrong");
    AST_OSC_MODE: assert property (rstn // R11
        |=> osc_mode == $past(cfg_word[rcs_pkg::CFG_OSC_HI:rcs_pkg::CFG_OSC_LO]))
        else $error("oscillator mode wrong");

    COV_DELAY_DONE: cover property (cur_reg.st == RCS_DELAY ##1 cur_reg.st == RCS_RUN);
    COV_BOR_RUN: cover property (cur_reg.st == RCS_RUN ##1 cur_reg.st == RCS_HOLD);
    COV_PIN_RST: cover property (pin_rst);
    COV_WDT_WAKE: cover property (cur_reg.st == RCS_RUN && watchdog_wake && watchdog_timeout);
    COV_SOFT_BOR: cover property (bor_mode == rcs_pkg::BOR_SOFT && bor_en);
endmodule : rcs_sequencer
`default_nettype wire

/* tb/rcs_sequencer_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module rcs_sequencer_bench;
    typedef struct packed {logic [15:0] cfg; logic [7:0] exp;} rcs_row_s;
    logic ref_clk, rstn, por_active, supply_below_threshold, rc_tick, sleep_active;
    logic crystal_settled, watchdog_timeout, watchdog_wake, bulk_erase_req, external_reset_n;
    logic reg_wr, reg_rd, pin_pullup_en, pin_drive_low, pin_drive_oe, pin_digital_in;
    logic chip_reset, settle_timer_run, osc_stop, freq_8mhz, code_lock, watchdog_enable;
    logic brownout_active, erase_program, erase_cal;
    logic [15:0] cfg_word, reg_addr, reg_rdata, q;
    logic [7:0] reg_wdata;
    logic [2:0] osc_mode;
    int err_total = 0;
    int n_compared = 0;
    // {freq, lock, watchdog, pullup, brown-out, osc mode}; top bits left 0 to see them read as 1
    rcs_row_s rows [8] = '{'{16'h03ff, 8'hbf}, '{16'h02b6, 8'hde}, '{16'h0155, 8'h05},
        '{16'h001c, 8'h64}, '{16'h00bb, 8'hf3}, '{16'h01fa, 8'hb2}, '{16'h0379, 8'h39},
        '{16'h0230, 8'h58}};

    rcs_sequencer i_rcs_sequencer (.ref_clk(ref_clk), .rstn(rstn), .cfg_word(cfg_word),
        .por_active(por_active), .supply_below_threshold(supply_below_threshold),
        .rc_tick(rc_tick), .sleep_active(sleep_active), .crystal_settled(crystal_settled),
        .watchdog_timeout(watchdog_timeout), .watchdog_wake(watchdog_wake),
        .bulk_erase_req(bulk_erase_req), .external_reset_n(external_reset_n),
        .pin_pullup_en(pin_pullup_en), .pin_drive_low(pin_drive_low),
        .pin_drive_oe(pin_drive_oe), .pin_digital_in(pin_digital_in), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .chip_reset(chip_reset), .settle_timer_run(settle_timer_run), .osc_stop(osc_stop),
        .freq_8mhz(freq_8mhz), .code_lock(code_lock), .watchdog_enable(watchdog_enable),
        .brownout_active(brownout_active), .osc_mode(osc_mode),
        .erase_program(erase_program), .erase_cal(erase_cal));

    initial
    begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    task automatic summarize();
        if (err_total == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : summarize

    task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic tick(int n);
        repeat (n) @(posedge ref_clk);
    endtask : tick

    task automatic reg_write(logic [15:0] a, logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : reg_write

    task automatic reg_read(logic [15:0] a, output logic [15:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : reg_read

    // bounded wait for the chip reset level; running out ends the run
    task automatic wait_rst(logic v, int n, string name);
        for (int i = 0; i < n; i++)
        begin
            @(posedge ref_clk);
            #1;
            if (chip_reset === v)
                break;
        end
        check(name, chip_reset, v);
        if (chip_reset !== v)
            summarize();
    endtask : wait_rst

    task automatic hold(logic v, int n, string name);
        repeat (n)
        begin
            @(posedge ref_clk);
            #1 check(name, chip_reset, v);
        end
    endtask : hold

    initial
    begin
        #1_000_000;
        err_total++;
        summarize();
    end

    initial
    begin
        rstn = 1'b0;
        por_active = 1'b1;
        supply_below_threshold = 1'b0;
        rc_tick = 1'b1;
        sleep_active = 1'b0;
        crystal_settled = 1'b1;
        watchdog_timeout = 1'b0;
        watchdog_wake = 1'b0;
        bulk_erase_req = 1'b0;
        external_reset_n = 1'b1;
        cfg_word = 16'h03ff;
        reg_addr = 16'h0000;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        tick(3);
        check("rst_chip_reset", chip_reset, 1'b1);
        check("rst_rdata", reg_rdata, 16'h0000);
        rstn <= 1'b1;
        hold(1'b1, 5, "por_hold");
        reg_write(rcs_pkg::POWER_CONTROL_REG_ADDR, 8'h02);
        reg_read(rcs_pkg::POWER_CONTROL_REG_ADDR, q);
        check("por_flag", q[1], 1'b0);
        reg_read(16'h0055, q);
        check("unmapped", q, 16'h0000);
        por_active <= 1'b0;
        wait_rst(1'b0, 60, "por_exit");
        // ---------------------------------------------------------------
        // decode table
        // ---------------------------------------------------------------
        foreach (rows[i])
        begin
            cfg_word <= rows[i].cfg;
            tick(4);
            #1 check("decode", {freq_8mhz, code_lock, watchdog_enable, pin_pullup_en,
                brownout_active, osc_mode}, rows[i].exp);
            reg_read(rcs_pkg::CFG_WORD_ADDR, q);
            check("cfg_read", q, rows[i].cfg | rcs_pkg::CFG_UNIMPL_MASK);
        end
        // ---------------------------------------------------------------
        // awkward cases
        // ---------------------------------------------------------------
        cfg_word <= 16'h03ff;
        for (int i = 0; i < 8; i++)
        begin
            @(posedge ref_clk);
            #1;
            if (erase_program === 1'b1)
                break;
        end
        check("unlock_erase", erase_program, 1'b1);
        bulk_erase_req <= 1'b1;
        tick(1);
        #1 check("bulk_erase", erase_program, 1'b1);
        bulk_erase_req <= 1'b0;
        tick(2);
        #1 check("erase_cal", erase_cal, 1'b0);
        check("erase_done", erase_program, 1'b0);
        reg_write(rcs_pkg::POWER_CONTROL_REG_ADDR, 8'h13);
        reg_read(rcs_pkg::POWER_CONTROL_REG_ADDR, q);
        check("power_control_reg_rw", q[4:0], 5'h13);
        cfg_word <= 16'h01ff;
        tick(4);
        #1 check("soft_on", brownout_active, 1'b1);
        cfg_word <= 16'h02ff;
        sleep_active <= 1'b1;
        tick(4);
        #1 check("sleep_off", brownout_active, 1'b0);
        sleep_active <= 1'b0;
        reg_write(rcs_pkg::POWER_CONTROL_REG_ADDR, 8'h03);
        tick(4);
        #1 check("wake_on", brownout_active, 1'b1);
        cfg_word <= 16'h01ff;
        tick(4);
        #1 check("soft_off", brownout_active, 1'b0);
        // pin reset with delay enabled and internal oscillator
        cfg_word <= 16'h03ec;
        external_reset_n <= 1'b0;
        tick(3);
        external_reset_n <= 1'b1;
        hold(1'b0, 12, "glitch");
        external_reset_n <= 1'b0;
        wait_rst(1'b1, 20, "pin_reset");
        tick(2);
        #1 check("osc_stop", osc_stop, 1'b1);
        check("pin_drive_low", pin_drive_low, 1'b0);
        external_reset_n <= 1'b1;
        wait_rst(1'b0, 40, "pin_no_delay");
        reg_read(rcs_pkg::POWER_CONTROL_REG_ADDR, q);
        check("por_kept", q[1:0], 2'b11);
        cfg_word <= 16'h03cc;
        tick(2);
        external_reset_n <= 1'b0;
        hold(1'b0, 20, "pin_as_input");
        check("digital_in", pin_digital_in, 1'b0);
        check("no_pullup", pin_pullup_en, 1'b0);
        external_reset_n <= 1'b1;
        // let the filtered pin settle high before it becomes a reset input again
        tick(10);
        #1 check("digital_in_hi", pin_digital_in, 1'b1);
        cfg_word <= 16'h03fc;
        tick(12);
        watchdog_timeout <= 1'b1;
        wait_rst(1'b1, 10, "wdt_reset");
        check("wdt_pin", {pin_drive_low, pin_drive_oe}, 2'b00);
        watchdog_timeout <= 1'b0;
        wait_rst(1'b0, 40, "wdt_exit");
        watchdog_wake <= 1'b1;
        watchdog_timeout <= 1'b1;
        tick(2);
        watchdog_timeout <= 1'b0;
        watchdog_wake <= 1'b0;
        hold(1'b0, 10, "wdt_wake");
        cfg_word <= 16'h03fa;
        crystal_settled <= 1'b0;
        tick(2);
        #1 check("settle_run", settle_timer_run, 1'b1);
        crystal_settled <= 1'b1;
        cfg_word <= 16'h03fc;
        // brown-out without delay, then with delay
        supply_below_threshold <= 1'b1;
        tick(2);
        supply_below_threshold <= 1'b0;
        hold(1'b0, 10, "bor_short");
        supply_below_threshold <= 1'b1;
        wait_rst(1'b1, 12, "bor_reset");
        hold(1'b1, 20, "bor_hold");
        supply_below_threshold <= 1'b0;
        wait_rst(1'b0, 40, "bor_exit");
        reg_read(rcs_pkg::POWER_CONTROL_REG_ADDR, q);
        check("bor_flag", q[1:0], 2'b10);
        cfg_word <= 16'h00fc;
        tick(2);
        supply_below_threshold <= 1'b1;
        hold(1'b0, 20, "bor_disabled");
        supply_below_threshold <= 1'b0;
        cfg_word <= 16'h03ec;
        tick(2);
        supply_below_threshold <= 1'b1;
        wait_rst(1'b1, 12, "bor_reset2");
        supply_below_threshold <= 1'b0;
        hold(1'b1, 200, "delay_hold");
        supply_below_threshold <= 1'b1;
        rc_tick <= 1'b0;
        tick(20);
        supply_below_threshold <= 1'b0;
        hold(1'b1, 300, "delay_restart");
        summarize();
    end
endmodule : rcs_sequencer_bench
`default_nettype wire
